// File: verilog/asr_core.v
// Accumulator saturation, overflow flags, trap request and write-back path.
`timescale 1ns/1ps
`include "asr_map.vh"


module asr_core (
   input  wire        clk_in,
   input  wire        rst_n_in,
   input  wire        op_valid_in,
   input  wire        op_target_b_in,
   input  wire [39:0] op_sum_in,
   input  wire        op_carry39_in,
   input  wire        op_is_mac_in,
   input  wire        op_excluded_in,
   input  wire        wb_req_in,
   input  wire        wb_indirect_in,
   input  wire        wb_round_in,
   input  wire        sat_en_a_in,
   input  wire        sat_en_b_in,
   input  wire        sat_mode32_in,
   input  wire        round_select_in,
   input  wire [15:0] reg_addr_in,
   input  wire [15:0] reg_wdata_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   output reg  [15:0] reg_rdata_out,
   output reg  [39:0] acc_a_out,
   output reg  [39:0] acc_b_out,
   output reg         xbus_wr_out,
   output reg  [15:0] xbus_addr_out,
   output reg  [15:0] xbus_wdata_out,
   output reg  [15:0] writeback_reg_out,
   output wire [15:0] cpu_status_word_out,
   output wire        trap_req_out,
   output wire        irq_out
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [15:0] fault_trap_control_r;
   reg         acc_a_clip_flag_r;
   reg         acc_b_clip_flag_r;
   reg         acc_a_guard_overflow_r;
   reg         acc_b_guard_overflow_r;
   reg  [3:0]  irq_stat_r;
   reg  [3:0]  irq_mask_r;
   reg  [15:0] writeback_pointer_reg_r;

   // ----------------------------------------
   // Overflow detection and clamp
   // ----------------------------------------
   wire        sat_en;
   wire        ovf39;
   wire        ovf31;
   wire        ovf_guard;
   wire        neg;
   wire        ovf_sel;
   reg  [39:0] acc_nxt;
   wire        clip_set;
   wire        guard_set;
   wire        wrap_event;
   wire        wrap_trap_en;
   wire [39:0] other_acc;
   wire [15:0] round_word;
   wire        wb_go;
   wire [3:0]  irq_evt;

   // True sign is the carry out beyond bit 39.
   assign neg       = op_carry39_in;
   assign sat_en    = op_target_b_in ? sat_en_b_in : sat_en_a_in;
   assign ovf39     = op_carry39_in ^ op_sum_in[39];
   assign ovf31     = ovf39 | (op_sum_in[39:31] != {9{op_sum_in[39]}});
   assign ovf_guard = ovf39 | (op_sum_in[39:31] != {9{op_sum_in[39]}});
   // 32-bit mode only applies when saturating; otherwise bit 39 governs.
   assign ovf_sel   = (sat_en & sat_mode32_in) ? ovf31 : ovf39;
   assign clip_set  = op_valid_in & ovf_sel;
   assign guard_set = op_valid_in & ovf_guard & ~(sat_en & sat_mode32_in);
   assign wrap_event = op_valid_in & ~sat_en & ovf39;
   assign wrap_trap_en = fault_trap_control_r[`ASR_TC_WRAP_TRAP_EN];

   always @* begin
      acc_nxt = op_sum_in;
      if (sat_en && ovf_sel) begin
         if (sat_mode32_in) begin
            acc_nxt = neg ? `ASR_MIN32 : `ASR_MAX32;
         end else begin
            acc_nxt = neg ? `ASR_MIN40 : `ASR_MAX40;
         end
      end
   end

   // ----------------------------------------
   // Write-back rounding
   // ----------------------------------------
   assign other_acc = op_target_b_in ? acc_a_out : acc_b_out;
   // Write-back is only honoured for qualifying multiply-accumulate ops.
   assign wb_go     = op_valid_in & wb_req_in & op_is_mac_in & ~op_excluded_in;

   asr_round u_round (
      .acc_in          (other_acc),
      .round_en_in     (wb_round_in),
      .round_select_in (round_select_in),
      .result_out      (round_word)
   );

   // ----------------------------------------
   // Accumulators and write-back state
   // ----------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_a_out               <= 40'h0000000000;
         acc_b_out               <= 40'h0000000000;
         xbus_wr_out             <= 1'b0;
         xbus_addr_out           <= 16'h0000;
         xbus_wdata_out          <= 16'h0000;
         writeback_reg_out       <= 16'h0000;
         writeback_pointer_reg_r <= 16'h0000;
      end else begin
         xbus_wr_out <= 1'b0;
         if (op_valid_in && !op_target_b_in) begin
            acc_a_out <= acc_nxt;
         end
         if (op_valid_in && op_target_b_in) begin
            acc_b_out <= acc_nxt;
         end
         if (reg_wr_in && reg_addr_in == `ASR_OFF_WB_PTR) begin
            writeback_pointer_reg_r <= reg_wdata_in;
         end
         if (wb_go && !wb_indirect_in) begin
            writeback_reg_out <= round_word;
         end
         if (wb_go && wb_indirect_in) begin
            xbus_wr_out             <= 1'b1;
            xbus_addr_out           <= writeback_pointer_reg_r;
            xbus_wdata_out          <= round_word;
            writeback_pointer_reg_r <= writeback_pointer_reg_r + `ASR_PTR_STEP;
         end
      end
   end

   // ----------------------------------------
   // Sticky flags and trap control
   // ----------------------------------------
   // Hardware set beats a software clear landing in the same cycle.
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fault_trap_control_r   <= `ASR_TC_RESET;
         acc_a_clip_flag_r      <= 1'b0;
         acc_b_clip_flag_r      <= 1'b0;
         acc_a_guard_overflow_r <= 1'b0;
         acc_b_guard_overflow_r <= 1'b0;
      end else begin
         if (reg_wr_in && reg_addr_in == `ASR_OFF_TRAP_CTRL) begin
            // Error bits sit outside the write mask, so software cannot wipe a pending trap.
            fault_trap_control_r <= (fault_trap_control_r & ~`ASR_TC_WMASK) |
                                    (reg_wdata_in & `ASR_TC_WMASK);
         end
         if (reg_wr_in && reg_addr_in == `ASR_OFF_FLAGS) begin
            acc_a_clip_flag_r      <= acc_a_clip_flag_r & reg_wdata_in[`ASR_FL_A_CLIP];
            acc_b_clip_flag_r      <= acc_b_clip_flag_r & reg_wdata_in[`ASR_FL_B_CLIP];
            acc_a_guard_overflow_r <= acc_a_guard_overflow_r & reg_wdata_in[`ASR_FL_A_GUARD];
            acc_b_guard_overflow_r <= acc_b_guard_overflow_r & reg_wdata_in[`ASR_FL_B_GUARD];
         end
         if (clip_set && !op_target_b_in) begin
            acc_a_clip_flag_r <= 1'b1;
         end
         if (clip_set && op_target_b_in) begin
            acc_b_clip_flag_r <= 1'b1;
         end
         if (guard_set && !op_target_b_in) begin
            acc_a_guard_overflow_r <= 1'b1;
         end
         if (guard_set && op_target_b_in) begin
            acc_b_guard_overflow_r <= 1'b1;
         end
         if (wrap_event && !op_target_b_in) begin
            fault_trap_control_r[`ASR_TC_COVA_ERR] <= 1'b1;
         end
         if (wrap_event && op_target_b_in) begin
            fault_trap_control_r[`ASR_TC_COVB_ERR] <= 1'b1;
         end
      end
   end

   assign cpu_status_word_out = {14'h0000,
                                 acc_a_guard_overflow_r | acc_b_guard_overflow_r,
                                 acc_a_clip_flag_r | acc_b_clip_flag_r};
   // Trap stays requested while a catastrophic error bit stands and traps are on.
   assign trap_req_out = wrap_trap_en &
                         (fault_trap_control_r[`ASR_TC_COVA_ERR] |
                          fault_trap_control_r[`ASR_TC_COVB_ERR]);

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   assign irq_evt = {xbus_wr_out, wrap_event & wrap_trap_en,
                     clip_set & op_target_b_in, clip_set & ~op_target_b_in};

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat_r <= 4'h0;
         irq_mask_r <= 4'h0;
      end else begin
         if (reg_wr_in && reg_addr_in == `ASR_OFF_IRQ_MASK) begin
            irq_mask_r <= reg_wdata_in[3:0];
         end
         if (reg_wr_in && reg_addr_in == `ASR_OFF_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata_in[3:0]) | irq_evt;
         end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
         end
      end
   end

   assign irq_out = |(irq_stat_r & irq_mask_r);

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `ASR_OFF_TRAP_CTRL: reg_rdata_out <= fault_trap_control_r;
            `ASR_OFF_STATUS:    reg_rdata_out <= cpu_status_word_out;
            `ASR_OFF_FLAGS:     reg_rdata_out <= {12'h000, acc_b_guard_overflow_r,
                                                  acc_a_guard_overflow_r,
                                                  acc_b_clip_flag_r, acc_a_clip_flag_r};
            `ASR_OFF_IRQ_STAT:  reg_rdata_out <= {12'h000, irq_stat_r};
            `ASR_OFF_IRQ_MASK:  reg_rdata_out <= {12'h000, irq_mask_r};
            `ASR_OFF_WB_REG:    reg_rdata_out <= writeback_reg_out;
            `ASR_OFF_WB_PTR:    reg_rdata_out <= writeback_pointer_reg_r;
            default:            reg_rdata_out <= 16'h0000;
         endcase
      end else begin
         reg_rdata_out <= 16'h0000;
      end
   end

endmodule

// File: include/asr_map.vh
// Register offsets, field positions, reset values and saturation constants.
`ifndef ASR_MAP_VH
`define ASR_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ASR_OFF_TRAP_CTRL   16'h0080
`define ASR_OFF_STATUS      16'h0100
`define ASR_OFF_FLAGS       16'h0102
`define ASR_OFF_IRQ_STAT    16'h0104
`define ASR_OFF_IRQ_MASK    16'h0106
`define ASR_OFF_WB_REG      16'h0108
`define ASR_OFF_WB_PTR      16'h010a

// ----------------------------------------
// Fault trap control fields
// ----------------------------------------
`define ASR_TC_WRAP_TRAP_EN 8
`define ASR_TC_COVA_ERR     12
`define ASR_TC_COVB_ERR     11
`define ASR_TC_OVA_ERR      14
`define ASR_TC_OVB_ERR      13
`define ASR_TC_RESET        16'h0000
`define ASR_TC_WMASK        16'h01ff

// ----------------------------------------
// Status word and flag fields
// ----------------------------------------
`define ASR_SW_ANY_GUARD    1
`define ASR_SW_ANY_CLIP     0
`define ASR_FL_A_CLIP       0
`define ASR_FL_B_CLIP       1
`define ASR_FL_A_GUARD      2
`define ASR_FL_B_GUARD      3

// ----------------------------------------
// Interrupt status fields
// ----------------------------------------
`define ASR_IRQ_CLIP_A      0
`define ASR_IRQ_CLIP_B      1
`define ASR_IRQ_WRAP_TRAP   2
`define ASR_IRQ_WB_STORE    3

// ----------------------------------------
// Saturation limits and write-back
// ----------------------------------------
`define ASR_MAX40           40'h7fffffffff
`define ASR_MIN40           40'h8000000000
`define ASR_MAX32           40'h007fffffff
`define ASR_MIN32           40'hff80000000
`define ASR_PTR_STEP        16'h0002
`define ASR_HALF_LSW        16'h8000

`endif

// File: verilog/asr_round.v
// Combinational round or truncate of an accumulator upper word.
`timescale 1ns/1ps
`include "asr_map.vh"

module asr_round (
   input  wire [39:0] acc_in,
   input  wire        round_en_in,
   input  wire        round_select_in,
   output wire [15:0] result_out
);

   wire [15:0] acc_upper_word;
   wire [15:0] acc_lower_word;
   wire        inc_conv;
   wire        inc_conv_tie;
   wire        inc;

   assign acc_upper_word = acc_in[31:16];
   assign acc_lower_word = acc_in[15:0];
   assign inc_conv       = acc_lower_word[15];
   // Exact half goes to the even neighbour.
   assign inc_conv_tie   = (acc_lower_word == `ASR_HALF_LSW) ? acc_in[16] : inc_conv;
   assign inc            = round_en_in & (round_select_in ? inc_conv_tie : inc_conv);
   // No rounding drops the lower word.
   assign result_out     = acc_upper_word + {15'h0000, inc};

endmodule

// File: tb/asr_core_checker.sv
// Port-level assertion checker for the accumulator saturation block.
`timescale 1ns/1ps
module asr_core_checker (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        op_valid_in,
   input wire logic        op_target_b_in,
   input wire logic [39:0] op_sum_in,
   input wire logic        op_carry39_in,
   input wire logic        op_is_mac_in,
   input wire logic        op_excluded_in,
   input wire logic        wb_req_in,
   input wire logic        wb_indirect_in,
   input wire logic        sat_en_a_in,
   input wire logic        sat_en_b_in,
   input wire logic        sat_mode32_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic [39:0] acc_a_out,
   input wire logic        xbus_wr_out,
   input wire logic [15:0] cpu_status_word_out
);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   wire sat_a = op_valid_in && !op_target_b_in && sat_en_a_in;
   AST_RD_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
      else $error("read data not zero outside read cycle");
   AST_CLIP_STICKY: assert property (cpu_status_word_out[0] && !reg_wr_in |=>
      cpu_status_word_out[0]) else $error("clip flag dropped without write");
   AST_CLIP_SET: assert property (sat_a && !sat_mode32_in &&
      (op_carry39_in ^ op_sum_in[39]) |=> cpu_status_word_out[0])
      else $error("clip flag not set on overflow");
   AST_SAT40_POS: assert property (sat_a && !sat_mode32_in && !op_carry39_in &&
      op_sum_in[39] |=> acc_a_out == 40'h7fffffffff) else $error("no positive clamp");
   AST_SAT40_NEG: assert property (sat_a && !sat_mode32_in && op_carry39_in &&
      !op_sum_in[39] |=> acc_a_out == 40'h8000000000) else $error("no negative clamp");
   AST_SAT32_POS: assert property (sat_a && sat_mode32_in && !op_carry39_in &&
      op_sum_in[39:31] != 9'h000 |=> acc_a_out == 40'h007fffffff)
      else $error("no 32-bit positive clamp");
   AST_GUARD32: assert property (op_valid_in && sat_en_a_in && sat_en_b_in &&
      sat_mode32_in && !cpu_status_word_out[1] |=> !cpu_status_word_out[1])
      else $error("guard flag set in 32-bit mode");
   AST_WRAP: assert property (op_valid_in && !op_target_b_in && !sat_en_a_in |=>
      acc_a_out == $past(op_sum_in)) else $error("accumulator clamped when off");
   AST_WB_STORE: assert property (op_valid_in && wb_req_in && wb_indirect_in &&
      op_is_mac_in && !op_excluded_in |=> xbus_wr_out) else $error("store missing");
   AST_WB_EXCL: assert property ((!op_valid_in || op_excluded_in) |=> !xbus_wr_out)
      else $error("store without qualifying operation");
endmodule

// File: tb/asr_xmem.sv
// Behavioural data-space memory taking write-back stores from the X bus.
`timescale 1ns/1ps
module asr_xmem (
   input  wire logic        clk_in,
   input  wire logic        wr_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] data_in,
   input  wire logic [15:0] rd_addr_in,
   output logic      [15:0] rd_data_out,
   output int               stores_out
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [15:0] mem_r [0:255];
   initial stores_out = 0;
   // Word stores only, so the low address bit is ignored; the space wraps at 512 bytes.
   always @(posedge clk_in) begin
      if (wr_in) begin
         mem_r[addr_in[8:1]] <= data_in;
         stores_out <= stores_out + 1;
      end
   end
   assign rd_data_out = mem_r[rd_addr_in[8:1]];
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the accumulator saturation and write-back block.
`timescale 1ns/1ps
`include "asr_map.vh"
module tb_top;
   logic        clk_in = 0, rst_n_in = 0, op_valid_in = 0, op_target_b_in = 0;
   logic        op_carry39_in = 0, op_is_mac_in = 0, op_excluded_in = 0, wb_req_in = 0;
   logic        wb_indirect_in = 0, wb_round_in = 0, sat_en_a_in = 0, sat_en_b_in = 0;
   logic        sat_mode32_in = 0, round_select_in = 0, reg_wr_in = 0, reg_rd_in = 0;
   logic [39:0] op_sum_in = 0;
   logic [15:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, d, mem_q;
   logic [39:0] acc_a_out, acc_b_out;
   logic [15:0] xbus_addr_out, xbus_wdata_out, writeback_reg_out, cpu_status_word_out;
   logic        xbus_wr_out, trap_req_out, irq_out, i1;
   int          fail_count = 0, tests_run = 0, stores, n;
   asr_core asr_core_inst (.*);
   asr_xmem asr_xmem_inst (.clk_in(clk_in), .wr_in(xbus_wr_out), .addr_in(xbus_addr_out),
      .data_in(xbus_wdata_out), .rd_addr_in(16'h0200), .rd_data_out(mem_q),
      .stores_out(stores));
   always #50 clk_in = ~clk_in;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= v;
      reg_wr_in    <= 1'b1;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
      #1 d = reg_rdata_out;
   endtask
   // Flag bits: 9 mode32, 8 sat B, 7 sat A, 6 mac, 5 excluded, 4 convergent, 3 round,
   // 2 indirect, 1 write-back, 0 target B.
   task automatic op(input logic [39:0] s, input logic c, input logic [9:0] f);
      @(posedge clk_in);
      op_sum_in     <= s;
      op_carry39_in <= c;
      {sat_mode32_in, sat_en_b_in, sat_en_a_in, op_is_mac_in, op_excluded_in,
       round_select_in, wb_round_in, wb_indirect_in, wb_req_in, op_target_b_in} <= f;
      op_valid_in   <= 1'b1;
      @(posedge clk_in);
      op_valid_in   <= 1'b0;
      wb_req_in     <= 1'b0;
      #1;
   endtask
   task automatic wbc(input logic [39:0] b, input logic [9:0] f, input logic [15:0] e);
      op(b, 1'b0, 10'h1c1);
      op(40'h0, 1'b0, f);
      chk("writeback_reg", writeback_reg_out, e);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      #(3000 * 100);
      fail_count++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk("status_rst", cpu_status_word_out, 0);
      rd(`ASR_OFF_TRAP_CTRL);
      chk("trap_ctrl_rst", d, `ASR_TC_RESET);
      op(40'h8000000000, 1'b0, 10'h1c0);
      chk("acc_a_max40", acc_a_out, `ASR_MAX40);
      chk("any_clip", cpu_status_word_out[0], 1);
      op(40'h7fffffffff, 1'b1, 10'h1c1);
      chk("acc_b_min40", acc_b_out, `ASR_MIN40);
      rd(`ASR_OFF_FLAGS);
      chk("clip_flags", d[1:0], 2'h3);
      wr(`ASR_OFF_FLAGS, 16'h0000);
      chk("status_clr", cpu_status_word_out, 0);
      op(40'h0100000000, 1'b0, 10'h1c0);
      chk("acc_guard", acc_a_out, 40'h0100000000);
      chk("any_guard", cpu_status_word_out, 16'h0002);
      wr(`ASR_OFF_FLAGS, 16'h0000);
      op(40'h0080000000, 1'b0, 10'h3c0);
      chk("acc_a_max32", acc_a_out, `ASR_MAX32);
      op(40'hff7fffffff, 1'b1, 10'h3c1);
      chk("acc_b_min32", acc_b_out, `ASR_MIN32);
      chk("status32", cpu_status_word_out, 16'h0001);
      wr(`ASR_OFF_TRAP_CTRL, 16'h0100);
      op(40'h8000000001, 1'b0, 10'h140);
      chk("acc_wrap", acc_a_out, 40'h8000000001);
      chk("trap_req", trap_req_out, 1);
      rd(`ASR_OFF_TRAP_CTRL);
      chk("trap_bits", d, 16'h1100);
      wr(`ASR_OFF_TRAP_CTRL, 16'hffff);
      rd(`ASR_OFF_TRAP_CTRL);
      chk("trap_mask", d, 16'h11ff);
      wr(`ASR_OFF_TRAP_CTRL, 16'h0000);
      chk("trap_off", trap_req_out, 0);
      wbc(40'h0012348000, 10'h1ca, 16'h1235);
      wbc(40'h0012347fff, 10'h1ca, 16'h1234);
      wbc(40'h0012348000, 10'h1da, 16'h1234);
      wbc(40'h0012358000, 10'h1da, 16'h1236);
      wbc(40'h001234ffff, 10'h1da, 16'h1235);
      wbc(40'h0012358000, 10'h1c2, 16'h1235);
      wr(`ASR_OFF_WB_PTR, 16'h0200);
      op(40'h0012348000, 1'b0, 10'h1c1);
      op(40'h0, 1'b0, 10'h1ce);
      chk("xbus_wr", xbus_wr_out, 1);
      chk("xbus_addr", xbus_addr_out, 16'h0200);
      rd(`ASR_OFF_WB_PTR);
      chk("wb_ptr", d, 16'h0202);
      chk("mem_word", mem_q, 16'h1235);
      n = stores;
      op(40'h0, 1'b0, 10'h1e6);
      op(40'h0, 1'b0, 10'h186);
      chk("no_store", 40'(stores - n), 0);
      wr(`ASR_OFF_IRQ_MASK, 16'h000f);
      i1 = irq_out;
      wr(`ASR_OFF_IRQ_MASK, 16'h0000);
      chk("irq_mask", i1 ^ irq_out, 1);
      rd(`ASR_OFF_IRQ_STAT);
      chk("irq_stat", d[3:0], 4'hf);
      wr(`ASR_OFF_IRQ_STAT, 16'h000f);
      rd(`ASR_OFF_IRQ_STAT);
      chk("irq_clr", {irq_out, d}, 0);
      wr(`ASR_OFF_WB_REG, 16'h5555);
      rd(`ASR_OFF_WB_REG);
      chk("wb_reg_ro", d, 16'h1235);
      rd(16'h0200);
      chk("unmapped", d, 0);
      stop_test();
   end
endmodule
bind asr_core asr_core_checker asr_core_checker_inst (.*);
